/* verilog/oneshot_timer_pkg.sv */
// Shared constants and carrier types for the output timer channel.
package oneshot_timer_pkg;

  // ----------------------------------------------------------------------
  // Widths and constants
  // ----------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------------
  // Modes and types
  // ----------------------------------------------------------------------
  typedef enum logic {
    MODE_DELAYED_SINGLE,
    MODE_CONTINUOUS
  } timer_mode_t;

  typedef struct packed {
    logic cnt_wr;
    logic [15:0] cnt_wdata;
    logic reload_wr;
    logic [15:0] reload_wdata;
    logic en_wr;
    logic en_wdata;
  } sw_ctrl_t;

  typedef struct packed {
    logic irq;
    logic dma_req;
  } timer_req_t;

endpackage

/* verilog/trigger_sync.sv */
// Three-stage synchroniser with rising edge detect for the trigger pin.
`timescale 1ns/1ps
module trigger_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin_in,
  output logic rise_pulse
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // The first stage feeds only the second, so metastability cannot leak.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      level_reg <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_reg <= s3_reg;
    end
  end

  assign rise_pulse = (s2_reg == s3_reg) && s3_reg && !level_reg;

endmodule

/* verilog/oneshot_delay_continuous_timer.sv */
// One output timer channel: delayed single-shot and continuous modes.
`timescale 1ns/1ps
// Notes on behaviour
// - Counting starts on enable write or trigger, after values are set.
// - Delayed single-shot counts down from the written counter value.
// - First underflow loads reload zero; second underflow stops counting.
// - Output toggles at first and second underflow: one pulse.
// - Delay is counter plus one ticks; width is reload plus one.
// - Single-shot raises interrupt and DMA requests at both underflows.
// - Underflow stop beats a same-cycle trigger enable.
// - Software enable beats a same-cycle underflow stop.
// - Software disable beats a same-cycle trigger enable.
// - Counter reads all ones in the cycle right after a reload.
// - Continuous mode reloads from reload zero on every underflow.
// - Continuous output toggles at start and every underflow.
// - Continuous mode runs until software clears the enable bit.
// - Continuous mode raises interrupt and DMA on every underflow.
// - First toggle waits for count clock after the enable event.
module oneshot_delay_continuous_timer #(
  parameter bit DMA_CAPABLE = 1'b1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire oneshot_timer_pkg::timer_mode_t mode,
  input wire oneshot_timer_pkg::sw_ctrl_t sw,
  input wire logic count_tick,
  input wire logic trig_pin,
  output logic running,
  output logic [15:0] count_rd,
  output logic [15:0] reload_rd,
  output logic io_output_timer,
  output oneshot_timer_pkg::timer_req_t req
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic trig_rise;
  logic running_reg;
  logic [15:0] cnt_reg;
  logic [15:0] reload_reg;
  logic second_reg;
  logic ff_reg;
  logic reload_flag_reg;
  logic [15:0] count_rd_reg;
  logic irq_reg;
  logic dma_reg;
  logic start_pend_reg;
  logic underflow;
  logic stop_uf;
  logic start_evt;
  logic sw_en;
  logic sw_dis;
  logic trig_en;

  trigger_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pin_in(trig_pin),
    .rise_pulse(trig_rise)
  );

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  assign sw_en = sw.en_wr && sw.en_wdata;
  assign sw_dis = sw.en_wr && !sw.en_wdata;
  // Disable write overrides a trigger in the same cycle.
  assign trig_en = trig_rise && !sw_dis;
  // Underflow is a tick while the counter already holds zero.
  assign underflow = running_reg && count_tick && (cnt_reg == 16'h0000);
  assign stop_uf = underflow &&
    (mode == oneshot_timer_pkg::MODE_DELAYED_SINGLE) && second_reg;
  assign start_evt = !running_reg && (sw_en || trig_en);

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      running_reg <= 1'b0;
    end else if (sw_dis) begin
      running_reg <= 1'b0;
    end else if (sw_en) begin
      running_reg <= 1'b1;
    end else if (stop_uf) begin
      running_reg <= 1'b0;
    end else if (trig_en) begin
      running_reg <= 1'b1;
    end
  end

  // The start toggle of continuous mode waits for the next count tick.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      start_pend_reg <= 1'b0;
    end else if (sw_dis) begin
      start_pend_reg <= 1'b0;
    end else if (start_evt && mode == oneshot_timer_pkg::MODE_CONTINUOUS) begin
      start_pend_reg <= 1'b1;
    end else if (count_tick) begin
      start_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Counter and reload zero
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reload_reg <= oneshot_timer_pkg::RELOAD_RESET;
    end else if (sw.reload_wr) begin
      reload_reg <= sw.reload_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= oneshot_timer_pkg::CNT_RESET;
    end else if (sw.cnt_wr) begin
      cnt_reg <= sw.cnt_wdata;
    end else if (underflow && !stop_uf) begin
      cnt_reg <= reload_reg;
    end else if (running_reg && count_tick && !stop_uf) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // Tracks which underflow of a single shot comes next.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      second_reg <= 1'b0;
    end else if (start_evt) begin
      second_reg <= 1'b0;
    end else if (underflow) begin
      second_reg <= !second_reg;
    end
  end

  // The read path shows all ones for one cycle after a reload.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reload_flag_reg <= 1'b0;
    end else begin
      reload_flag_reg <= underflow && !stop_uf && !sw.cnt_wr;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_rd_reg <= oneshot_timer_pkg::CNT_RESET;
    end else if (underflow && !stop_uf && !sw.cnt_wr) begin
      count_rd_reg <= oneshot_timer_pkg::CNT_ALL_ONES;
    end else if (sw.cnt_wr) begin
      count_rd_reg <= sw.cnt_wdata;
    end else if (running_reg && count_tick && !stop_uf) begin
      count_rd_reg <= cnt_reg - 16'h0001;
    end else begin
      count_rd_reg <= cnt_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Output flip-flop and requests
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ff_reg <= 1'b0;
    end else if (underflow) begin
      ff_reg <= !ff_reg;
    end else if (start_pend_reg && count_tick && running_reg) begin
      ff_reg <= !ff_reg;
    end
  end

  // Every underflow requests service in both modes.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
      dma_reg <= 1'b0;
    end else begin
      irq_reg <= underflow;
      dma_reg <= underflow && DMA_CAPABLE;
    end
  end

  assign running = running_reg;
  assign count_rd = count_rd_reg;
  assign reload_rd = reload_reg;
  assign io_output_timer = ff_reg;
  assign req.irq = irq_reg;
  assign req.dma_req = dma_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_stop_wins;
    @(posedge mclk) disable iff (!rstn)
      stop_uf && !sw_en |=> !running_reg;
  endproperty
  a_stop_wins: assert property (p_stop_wins)
    else $error("underflow stop did not halt counter");

  property p_sw_en_wins;
    @(posedge mclk) disable iff (!rstn)
      sw_en && !sw_dis |=> running_reg;
  endproperty
  a_sw_en_wins: assert property (p_sw_en_wins)
    else $error("software enable lost");

  property p_dis_wins;
    @(posedge mclk) disable iff (!rstn)
      sw_dis && trig_rise |=> !running_reg;
  endproperty
  a_dis_wins: assert property (p_dis_wins)
    else $error("disable did not beat trigger");

  property p_all_ones;
    @(posedge mclk) disable iff (!rstn)
      underflow && !stop_uf && !sw.cnt_wr |=>
        reload_flag_reg && count_rd == oneshot_timer_pkg::CNT_ALL_ONES;
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("counter read not all ones after reload");

  property p_reload;
    @(posedge mclk) disable iff (!rstn)
      underflow && !stop_uf && !sw.cnt_wr |=> cnt_reg == $past(reload_reg);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded on underflow");

  property p_toggle;
    @(posedge mclk) disable iff (!rstn)
      underflow |=> io_output_timer != $past(io_output_timer);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output did not toggle on underflow");

  property p_irq;
    @(posedge mclk) disable iff (!rstn)
      underflow |=> req.irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt request on underflow");

  property p_decrement;
    @(posedge mclk) disable iff (!rstn)
      running_reg && count_tick && cnt_reg != 16'h0000 && !sw.cnt_wr
        |=> cnt_reg == $past(cnt_reg) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down");

  property p_reload_shown;
    @(posedge mclk) disable iff (!rstn)
      reload_flag_reg && !sw.cnt_wr && !count_tick |=>
        count_rd == $past(cnt_reg);
  endproperty
  a_reload_shown: assert property (p_reload_shown)
    else $error("counter read did not return to the reloaded value");

  property p_dma;
    @(posedge mclk) disable iff (!rstn)
      underflow |=> req.dma_req == DMA_CAPABLE;
  endproperty
  a_dma: assert property (p_dma)
    else $error("DMA request does not follow underflow");

  // The start toggle is tied to a tick so that it stays on the count grid.
  property p_start_toggle;
    @(posedge mclk) disable iff (!rstn)
      start_pend_reg && count_tick && running_reg && !underflow |=>
        io_output_timer != $past(io_output_timer);
  endproperty
  a_start_toggle: assert property (p_start_toggle)
    else $error("output did not toggle at continuous start");

  property p_cont_runs;
    @(posedge mclk) disable iff (!rstn)
      running_reg && mode == oneshot_timer_pkg::MODE_CONTINUOUS && !sw_dis
        |=> running_reg;
  endproperty
  a_cont_runs: assert property (p_cont_runs)
    else $error("continuous count stopped without a disable write");

  property p_single_halt;
    @(posedge mclk) disable iff (!rstn)
      stop_uf && !sw_en && !sw.cnt_wr |=> cnt_reg == 16'h0000;
  endproperty
  a_single_halt: assert property (p_single_halt)
    else $error("counter moved at the single-shot stop");

  // A stopped channel must ignore ticks, or a later start would be short.
  property p_idle_hold;
    @(posedge mclk) disable iff (!rstn)
      !running_reg && !sw.cnt_wr |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("counter moved while stopped");

  c_single_done: cover property (@(posedge mclk) disable iff (!rstn)
    stop_uf);
  c_cont_reload: cover property (@(posedge mclk) disable iff (!rstn)
    underflow && mode == oneshot_timer_pkg::MODE_CONTINUOUS);
  c_trig_start: cover property (@(posedge mclk) disable iff (!rstn)
    trig_en && !running_reg);
  c_dis_vs_trig: cover property (@(posedge mclk) disable iff (!rstn)
    sw_dis && trig_rise);

endmodule

/* tb/host_model.sv */
// Host software and trigger pin model for the timer channel.
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  output oneshot_timer_pkg::sw_ctrl_t sw,
  output logic trig_pin
);
  initial begin
    sw = '0;
    trig_pin = 1'b0;
  end
  // Values go in before any enable write.
  task automatic setup(input logic [15:0] c, input logic [15:0] r);
    @(posedge mclk);
    sw.cnt_wr <= 1'b1;
    sw.cnt_wdata <= c;
    sw.reload_wr <= 1'b1;
    sw.reload_wdata <= r;
    @(posedge mclk);
    sw.cnt_wr <= 1'b0;
    sw.reload_wr <= 1'b0;
    // Stale data must not look valid once the strobe drops.
    sw.cnt_wdata <= ~c;
    sw.reload_wdata <= ~r;
  endtask
  // Only software stops continuous counting.
  task automatic wr_en(input logic v, input int n);
    @(posedge mclk);
    sw.en_wr <= 1'b1;
    sw.en_wdata <= v;
    repeat (n) @(posedge mclk);
    sw.en_wr <= 1'b0;
    sw.en_wdata <= ~v;
  endtask
  task automatic trig(input logic v);
    @(posedge mclk);
    trig_pin <= v;
  endtask
endmodule

/* tb/test_oneshot_delay_continuous_timer.sv */
// Self-checking bench for the output timer channel.
`timescale 1ns/1ps
module test_oneshot_delay_continuous_timer;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic count_tick = 1'b0;
  oneshot_timer_pkg::timer_mode_t mode;
  oneshot_timer_pkg::sw_ctrl_t sw;
  oneshot_timer_pkg::timer_req_t req;
  logic trig_pin, running, io_output_timer, io_prev, ff_on, nxt;
  logic [15:0] count_rd, reload_rd, rel;
  int err_count = 0, check_count = 0, ticks = 0, cyc = 0;
  int q_irq[$], q_tog[$], e_irq[$], e_tog[$];
  initial mode = oneshot_timer_pkg::MODE_DELAYED_SINGLE;
  always #2 mclk = ~mclk;
  host_model i_host (.mclk(mclk), .sw(sw), .trig_pin(trig_pin));
  oneshot_delay_continuous_timer i_dut (.mclk(mclk), .rstn(rstn),
    .mode(mode), .sw(sw), .count_tick(count_tick), .trig_pin(trig_pin),
    .running(running), .count_rd(count_rd), .reload_rd(reload_rd),
    .io_output_timer(io_output_timer), .req(req));
  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic end_sim();
    $display("Compared %0d mismatched %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_q(input int got[$], input int exp[$]);
    cmp16(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < got.size()) cmp16(16'(got[i]), 16'(exp[i]));
  endtask
  // Events are logged by the tick index that caused them.
  // Outputs are sampled on the falling edge, where they have settled.
  always @(negedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
    if (nxt) cmp16(count_rd, rel);
    nxt = 1'b0;
    if (req.irq === 1'b1) begin
      q_irq.push_back(ticks);
      cmp16({15'h0, req.dma_req}, 16'h0001);
      if (ff_on) cmp16(count_rd, oneshot_timer_pkg::CNT_ALL_ONES);
      nxt = ff_on;
      if (mode == oneshot_timer_pkg::MODE_DELAYED_SINGLE) ff_on = 1'b0;
    end
    if (io_output_timer !== io_prev) q_tog.push_back(ticks);
    io_prev = io_output_timer;
    if (count_tick) ticks++;
  end
  // --------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------
  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge mclk);
      count_tick <= 1'b1;
      @(posedge mclk);
      count_tick <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
  task automatic run(input logic m, input logic by_pin);
    int c;
    c = $urandom_range(1, 7);
    rel = 16'($urandom_range(0, 7));
    @(posedge mclk);
    mode <= oneshot_timer_pkg::timer_mode_t'(m);
    q_irq.delete();
    q_tog.delete();
    e_irq.delete();
    e_tog.delete();
    ticks = 0;
    ff_on = 1'b1;
    i_host.setup(16'(c), rel);
    if (by_pin) i_host.trig(1'b1);
    else i_host.wr_en(1'b1, 1);
    for (int i = 0; i < 8 && running !== 1'b1; i++) @(negedge mclk);
    cmp16({15'h0, running}, 16'h0001);
    cmp16(reload_rd, rel);
    if (m) e_tog.push_back(1);
    for (int k = 0; k < (m ? 3 : 2); k++) begin
      e_irq.push_back(c + 1 + k * (int'(rel) + 1));
      e_tog.push_back(c + 1 + k * (int'(rel) + 1));
    end
    tick_n(c + 1 + 2 * (int'(rel) + 1));
    @(negedge mclk);
    cmp16({15'h0, running}, {15'h0, m});
    i_host.wr_en(1'b0, 1);
    i_host.trig(1'b0);
    tick_n(3);
    cmp16({15'h0, running}, 16'h0000);
    cmp_q(q_irq, e_irq);
    cmp_q(q_tog, e_tog);
    $display("Test done mode %0d pin %0d", m, by_pin);
  endtask
  initial begin
    io_prev = 1'b0;
    nxt = 1'b0;
    ff_on = 1'b0;
    void'($urandom(32'h4070));
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    run(1'b0, 1'b1);
    run(1'b1, 1'b1);
    // A pin start inside a window of disable writes never runs.
    i_host.trig(1'b1);
    fork
      i_host.wr_en(1'b0, 8);
      repeat (10) begin
        @(negedge mclk);
        cmp16({15'h0, running}, 16'h0000);
      end
    join
    i_host.trig(1'b0);
    $display("Test done trigger against disable");
    end_sim();
  end
endmodule
